// *** hdl/bsl_pkg.sv ***
// shared constants and types for the strap latch
package bsl_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int STRAP_W = 16;
  localparam int USER_W = 8;
  localparam int ID_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // strap bit positions
  // ----------------------------------------------------------------
  localparam int BIT_DEBOUNCE = 0;
  localparam int BIT_MGMT_MODE = 3;
  localparam int BIT_ID_LSB = 4;
  localparam int BIT_EEPROM_ABSENT = 7;
  localparam int BIT_MOD_DETECT = 9;
  localparam int BIT_MFG_LOW = 10;
  localparam int BIT_PWR_SAVE = 11;
  localparam int BIT_TMO_RESET = 12;
  localparam logic [15:0] MUST_HIGH_MASK = 16'hE106;

  // status outputs after reset
  localparam int SO_INIT_START = 0;
  localparam int SO_SELFTEST = 1;
  localparam int SO_INIT_DONE = 2;
  localparam int SO_CKSUM_GOOD = 3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_USER = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam int CTRL_STAT_DRV = 0;
  localparam int STAT_VALID = 0;
  localparam int STAT_FAULT_HI = 1;
  localparam int STAT_FAULT_LO = 2;
  localparam int STAT_SAMPLING = 3;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] STRAP_RST = 16'h0000;
  localparam logic [7:0] USER_RST = 8'h00;
  localparam logic CTRL_DRV_RST = 1'b1;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_RAW = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;

  typedef enum logic [1:0] {BSL_ST_HOLD, BSL_ST_SETTLE, BSL_ST_RUN} bsl_state_t;

endpackage

// *** hdl/bsl_cfg_if.sv ***
// decoded strap configuration passed between latch and decoder
`timescale 1ns/1ps
interface bsl_cfg_if;
  logic [15:0] raw;
  logic debounce_en;
  logic mgmt_unmanaged;
  logic [2:0] device_id;
  logic eeprom_absent;
  logic module_detect_en;
  logic mac_power_save_en;
  logic timeout_reset_en;
  logic fault_high;
  logic fault_low;
  modport decoder (input raw, output debounce_en, mgmt_unmanaged, device_id, eeprom_absent,
    module_detect_en, mac_power_save_en, timeout_reset_en, fault_high, fault_low);
  modport user (output raw, input debounce_en, mgmt_unmanaged, device_id, eeprom_absent,
    module_detect_en, mac_power_save_en, timeout_reset_en, fault_high, fault_low);
endinterface

// *** hdl/bsl_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bsl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins and filtered result
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("bsl_sync width must be at least one");
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // a bit moves only once stages two and three agree
      dout <= (s2_ff & s3_ff) | (dout & (s2_ff ^ s3_ff));
    end
  end
endmodule

// *** hdl/bsl_decode.sv ***
// strap word to configuration field decoder
`timescale 1ns/1ps
module bsl_decode
  import bsl_pkg::*;
(
  // captured straps in, fields out
  bsl_cfg_if.decoder cfg
);
  // a pulled-up strap reads as one, pulled-down as zero, no inversion
  assign cfg.debounce_en = cfg.raw[BIT_DEBOUNCE];
  assign cfg.mgmt_unmanaged = cfg.raw[BIT_MGMT_MODE];
  assign cfg.device_id = cfg.raw[BIT_ID_LSB +: ID_W];
  assign cfg.eeprom_absent = cfg.raw[BIT_EEPROM_ABSENT];
  assign cfg.module_detect_en = cfg.raw[BIT_MOD_DETECT];
  assign cfg.mac_power_save_en = cfg.raw[BIT_PWR_SAVE];
  assign cfg.timeout_reset_en = cfg.raw[BIT_TMO_RESET];
  // board strapping faults are only reported, never acted on
  assign cfg.fault_high = (cfg.raw & MUST_HIGH_MASK) != MUST_HIGH_MASK;
  assign cfg.fault_low = cfg.raw[BIT_MFG_LOW];
endmodule

// *** hdl/bsl_top.sv ***
// strap latch: samples configuration pins during reset and holds them
// Function
// - straps and transmit-enable pins are sampled only while reset is in progress
// - a strap sampled high means one, sampled low means zero
// - strap bit 0 high enables strobe debounce, low disables it
// - strap bit 3 low selects lightly managed, high selects unmanaged serial
// - strap bits 6 to 4 form the three-bit default device identifier
// - strap bit 4 is the identifier's least significant bit
// - strap bit 7 high means no EEPROM fitted, low means fitted
// - strap bit 9 high enables module detection, low disables it
// - strap bit 11 high enables MAC power saving, low disables it
// - strap bit 12 high enables the timeout reset, low disables it
// - eight transmit-enable straps are captured and readable through a readback register
// - after reset strap pins 3 to 0 report checksum, done, self-test, start
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module bsl_top
  import bsl_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // reset pin from the board
  input wire logic reset_input_n,
  // strap and status pins
  input wire logic [STRAP_W-1:0] strap_status_bus_i,
  output logic [STRAP_W-1:0] strap_status_bus_o,
  output logic strap_status_bus_oe,
  // per-port transmit enable pins
  input wire logic [USER_W-1:0] port_transmit_enable_i,
  output logic [USER_W-1:0] port_transmit_enable_o,
  output logic port_transmit_enable_oe,
  // transmit enables from the MACs
  input wire logic [USER_W-1:0] mac_txen,
  // status from the switch core
  input wire logic init_started,
  input wire logic selftest_busy,
  input wire logic init_done,
  input wire logic cksum_good,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // configuration outputs
  output logic cfg_valid,
  output logic debounce_en,
  output logic mgmt_unmanaged,
  output logic [ID_W-1:0] device_id,
  output logic eeprom_absent,
  output logic module_detect_en,
  output logic mac_power_save_en,
  output logic timeout_reset_en,
  output logic [USER_W-1:0] user_strap
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << CNT_W)) begin : g_chk
      $error("settle count out of counter range");
    end
  endgenerate

  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
  localparam int PIN_W = STRAP_W + USER_W + 1;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_s;
  logic [STRAP_W-1:0] strap_s;
  logic [USER_W-1:0] txen_s;
  logic rstpin_s;

  bsl_sync #(
    .WIDTH(PIN_W),
    .RST_VAL('0)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({reset_input_n, port_transmit_enable_i, strap_status_bus_i}),
    .dout(pins_s)
  );

  assign strap_s = pins_s[STRAP_W-1:0];
  assign txen_s = pins_s[STRAP_W +: USER_W];
  assign rstpin_s = pins_s[PIN_W-1];

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  bsl_state_t state_ff;
  bsl_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic capture;

  // capture once the pins have settled for the full window
  assign capture = (state_ff == BSL_ST_SETTLE) && rstpin_s && (cnt_ff == SETTLE_LAST);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BSL_ST_HOLD: begin
        if (rstpin_s) begin
          nxt_state = BSL_ST_SETTLE;
        end
      end
      BSL_ST_SETTLE: begin
        if (!rstpin_s) begin
          nxt_state = BSL_ST_HOLD;
        end else if (capture) begin
          nxt_state = BSL_ST_RUN;
        end
      end
      BSL_ST_RUN: begin
        // a new reset pulse on the pin reopens the sampling window
        if (!rstpin_s) begin
          nxt_state = BSL_ST_HOLD;
        end
      end
      default: begin
        nxt_state = BSL_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= BSL_ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (state_ff != BSL_ST_SETTLE || !rstpin_s || capture) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic [STRAP_W-1:0] strap_ff;
  logic [USER_W-1:0] user_ff;
  logic valid_ff;

  // sampled only inside the reset window, held through normal operation
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_ff <= STRAP_RST;
      user_ff <= USER_RST;
    end else if (capture) begin
      strap_ff <= strap_s;
      user_ff <= txen_s;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= 1'b0;
    end else if (capture) begin
      valid_ff <= 1'b1;
    end else if (state_ff != BSL_ST_RUN) begin
      valid_ff <= 1'b0;
    end
  end

  bsl_cfg_if u_cfg ();

  assign u_cfg.raw = strap_ff;

  bsl_decode u_dec (
    .cfg(u_cfg)
  );

  assign cfg_valid = valid_ff;
  assign debounce_en = u_cfg.debounce_en;
  assign mgmt_unmanaged = u_cfg.mgmt_unmanaged;
  assign device_id = u_cfg.device_id;
  assign eeprom_absent = u_cfg.eeprom_absent;
  assign module_detect_en = u_cfg.module_detect_en;
  assign mac_power_save_en = u_cfg.mac_power_save_en;
  assign timeout_reset_en = u_cfg.timeout_reset_en;
  assign user_strap = user_ff;

  // ----------------------------------------------------------------
  // pin drive after reset
  // ----------------------------------------------------------------
  logic drv_ff;
  logic [STRAP_W-1:0] so_ff;
  logic so_oe_ff;
  logic [USER_W-1:0] txo_ff;
  logic txo_oe_ff;

  // straps are released while sampling so the board resistors win
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      so_ff <= '0;
      so_oe_ff <= 1'b0;
    end else begin
      so_oe_ff <= (nxt_state == BSL_ST_RUN) && drv_ff;
      so_ff <= '0;
      so_ff[SO_INIT_START] <= init_started;
      so_ff[SO_SELFTEST] <= selftest_busy;
      so_ff[SO_INIT_DONE] <= init_done;
      so_ff[SO_CKSUM_GOOD] <= cksum_good;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txo_ff <= '0;
      txo_oe_ff <= 1'b0;
    end else begin
      txo_oe_ff <= (nxt_state == BSL_ST_RUN);
      txo_ff <= (nxt_state == BSL_ST_RUN) ? mac_txen : '0;
    end
  end

  assign strap_status_bus_o = so_ff;
  assign strap_status_bus_oe = so_oe_ff;
  assign port_transmit_enable_o = txo_ff;
  assign port_transmit_enable_oe = txo_oe_ff;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdata_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drv_ff <= CTRL_DRV_RST;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      drv_ff <= reg_wdata[CTRL_STAT_DRV];
    end
  end

  // data stand for one cycle only; unmapped offsets read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= '0;
      if (reg_rd) begin
        case (reg_addr)
          OFS_CFG: rdata_ff <= {{(DATA_W-STRAP_W){1'b0}}, strap_ff};
          OFS_USER: rdata_ff <= {{(DATA_W-USER_W){1'b0}}, user_ff};
          OFS_STAT: begin
            rdata_ff[STAT_VALID] <= valid_ff;
            rdata_ff[STAT_FAULT_HI] <= u_cfg.fault_high;
            rdata_ff[STAT_FAULT_LO] <= u_cfg.fault_low;
            rdata_ff[STAT_SAMPLING] <= (state_ff != BSL_ST_RUN);
          end
          OFS_CTRL: rdata_ff[CTRL_STAT_DRV] <= drv_ff;
          default: rdata_ff <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_capture;
    capture;
  endsequence

  sequence s_run_steady;
    (state_ff == BSL_ST_RUN) ##1 (state_ff == BSL_ST_RUN);
  endsequence

  property p_no_drive_sampling;
    @(posedge mclk) disable iff (!rst_n)
    (state_ff != BSL_ST_RUN) |-> !port_transmit_enable_oe && !strap_status_bus_oe;
  endproperty
  a_no_drive_sampling: assert property (p_no_drive_sampling)
    else $error("pins driven while straps are sampled");

  property p_capture_value;
    @(posedge mclk) disable iff (!rst_n)
    s_capture |=> (strap_ff == $past(strap_s)) && cfg_valid;
  endproperty
  a_capture_value: assert property (p_capture_value)
    else $error("captured strap word differs from sampled pins");

  property p_debounce;
    @(posedge mclk) disable iff (!rst_n)
    s_capture |=> debounce_en == $past(strap_s[BIT_DEBOUNCE]);
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("debounce enable does not follow strap bit 0");

  property p_mgmt;
    @(posedge mclk) disable iff (!rst_n)
    s_capture |=> mgmt_unmanaged == $past(strap_s[BIT_MGMT_MODE]);
  endproperty
  a_mgmt: assert property (p_mgmt)
    else $error("management mode does not follow strap bit 3");

  property p_device_id;
    @(posedge mclk) disable iff (!rst_n)
    s_capture |=> device_id == {$past(strap_s[6]), $past(strap_s[5]), $past(strap_s[4])};
  endproperty
  a_device_id: assert property (p_device_id)
    else $error("device identifier bit order wrong");

  property p_misc_enables;
    @(posedge mclk) disable iff (!rst_n)
    cfg_valid |-> eeprom_absent == strap_ff[7] && module_detect_en == strap_ff[9]
      && mac_power_save_en == strap_ff[11] && timeout_reset_en == strap_ff[12];
  endproperty
  a_misc_enables: assert property (p_misc_enables)
    else $error("enable outputs do not follow their strap bits");

  property p_user_readback;
    @(posedge mclk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_USER) |=> reg_rdata == {24'h000000, $past(user_ff)} ##1
      ($past(reg_rd) || reg_rdata == 32'h00000000);
  endproperty
  a_user_readback: assert property (p_user_readback)
    else $error("user strap readback wrong");

  property p_status_out;
    @(posedge mclk) disable iff (!rst_n)
    (nxt_state == BSL_ST_RUN && drv_ff) |=> strap_status_bus_oe
      && strap_status_bus_o[3:0] == {$past(cksum_good), $past(init_done),
      $past(selftest_busy), $past(init_started)} && strap_status_bus_o[15:4] == 12'h000;
  endproperty
  a_status_out: assert property (p_status_out)
    else $error("status outputs wrong after reset");

  property p_hold_stable;
    @(posedge mclk) disable iff (!rst_n)
    s_run_steady |-> $stable(strap_ff) && $stable(user_ff) && cfg_valid;
  endproperty
  a_hold_stable: assert property (p_hold_stable)
    else $error("captured straps changed during normal operation");

  property p_settle_len;
    @(posedge mclk) disable iff (!rst_n)
    $rose(state_ff == BSL_ST_SETTLE) ##1 (rstpin_s && state_ff == BSL_ST_SETTLE) |->
      !cfg_valid;
  endproperty
  a_settle_len: assert property (p_settle_len)
    else $error("configuration valid before the settle window ended");

endmodule

// *** test/bsl_board_model.sv ***
// board strap resistors and pin resolution for the strap latch
`timescale 1ns/1ps
module bsl_board_model
  import bsl_pkg::*;
(
  // resistor pattern fitted for this boot
  input wire logic [STRAP_W-1:0] strap_pattern,
  input wire logic [USER_W-1:0] user_pattern,
  // device side of the shared pins
  input wire logic [STRAP_W-1:0] strap_drv,
  input wire logic strap_drv_oe,
  input wire logic [USER_W-1:0] txen_drv,
  input wire logic txen_drv_oe,
  // resolved pin levels
  output logic [STRAP_W-1:0] strap_pin,
  output logic [USER_W-1:0] txen_pin
);
  logic [STRAP_W-1:0] fitted;
  // reserved and manufacturing straps are soldered, never chosen per boot
  assign fitted = (strap_pattern | MUST_HIGH_MASK) & ~16'h0400;
  // a released pin falls back to its resistor level
  assign strap_pin = strap_drv_oe ? strap_drv : fitted;
  assign txen_pin = txen_drv_oe ? txen_drv : user_pattern;
endmodule

// *** test/test_bootstrap_strap_latch.sv ***
// self-checking testbench for the strap latch
`timescale 1ns/1ps
module test_bootstrap_strap_latch;
  import bsl_pkg::*;
  localparam int TIMEOUT_CYC = 20000;
  logic mclk, rst_n, reset_input_n, strap_oe, txen_oe, reg_wr, reg_rd;
  logic [STRAP_W-1:0] strap_pin, strap_o, strap_pattern, exp_s;
  logic [USER_W-1:0] txen_pin, txen_o, user_pattern, mac_txen, exp_u, user_strap;
  logic init_started, selftest_busy, init_done, cksum_good;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;
  logic cfg_valid, debounce_en, mgmt_unmanaged, eeprom_absent, module_detect_en;
  logic mac_power_save_en, timeout_reset_en;
  logic [ID_W-1:0] device_id;
  int failures, checks_done, cycles, seed, n;

  bsl_top #(.SETTLE_CYCLES(2)) bsl_top_inst (.mclk(mclk), .rst_n(rst_n),
    .reset_input_n(reset_input_n), .strap_status_bus_i(strap_pin),
    .strap_status_bus_o(strap_o), .strap_status_bus_oe(strap_oe),
    .port_transmit_enable_i(txen_pin), .port_transmit_enable_o(txen_o),
    .port_transmit_enable_oe(txen_oe), .mac_txen(mac_txen), .init_started(init_started),
    .selftest_busy(selftest_busy), .init_done(init_done), .cksum_good(cksum_good),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cfg_valid(cfg_valid), .debounce_en(debounce_en),
    .mgmt_unmanaged(mgmt_unmanaged), .device_id(device_id), .eeprom_absent(eeprom_absent),
    .module_detect_en(module_detect_en), .mac_power_save_en(mac_power_save_en),
    .timeout_reset_en(timeout_reset_en), .user_strap(user_strap));

  bsl_board_model bsl_board_model_inst (.strap_pattern(strap_pattern),
    .user_pattern(user_pattern), .strap_drv(strap_o), .strap_drv_oe(strap_oe),
    .txen_drv(txen_o), .txen_drv_oe(txen_oe), .strap_pin(strap_pin), .txen_pin(txen_pin));

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  always #25 mclk = ~mclk;

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == TIMEOUT_CYC) begin
      failures++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // expectations, compares and bus cycles
  // ----------------------------------------------------------------
  function automatic logic [15:0] fitted(input logic [15:0] s);
    return (s | 16'hE106) & ~16'h0400;
  endfunction

  task automatic check_field(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
    checks_done++;
    if (rd !== exp) begin
      failures++;
      $display("Error reg %h expected %h seen %h", a, exp, rd);
    end
  endtask

  // pins wiggle while the board reset is low; only the settled pattern counts
  task automatic boot(input logic [15:0] s, input logic [7:0] u, input logic [31:0] stat);
    @(posedge mclk);
    reset_input_n <= 1'b0;
    strap_pattern <= ~s;
    user_pattern <= ~u;
    repeat (5) @(posedge mclk);
    strap_pattern <= s;
    user_pattern <= u;
    repeat (5) @(posedge mclk);
    #1;
    check_field("cfg_valid low", 32'h0, {31'h0, cfg_valid});
    check_field("strap oe low", 32'h0, {31'h0, strap_oe});
    check_field("txen oe low", 32'h0, {31'h0, txen_oe});
    check_reg(OFS_STAT, stat);
    @(posedge mclk);
    reset_input_n <= 1'b1;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    #1;
  endtask

  task automatic check_cfg(input logic [15:0] s, input logic [7:0] u);
    check_field("cfg_valid", 32'h1, {31'h0, cfg_valid});
    check_field("debounce_en", {31'h0, s[0]}, {31'h0, debounce_en});
    check_field("mgmt_unmanaged", {31'h0, s[3]}, {31'h0, mgmt_unmanaged});
    check_field("device_id", {29'h0, s[6:4]}, {29'h0, device_id});
    check_field("device_id lsb", {31'h0, s[4]}, {31'h0, device_id[0]});
    check_field("eeprom_absent", {31'h0, s[7]}, {31'h0, eeprom_absent});
    check_field("module_detect_en", {31'h0, s[9]}, {31'h0, module_detect_en});
    check_field("mac_power_save_en", {31'h0, s[11]}, {31'h0, mac_power_save_en});
    check_field("timeout_reset_en", {31'h0, s[12]}, {31'h0, timeout_reset_en});
    check_field("user_strap", {24'h0, u}, {24'h0, user_strap});
    check_reg(OFS_CFG, {16'h0, s});
    check_reg(OFS_USER, {24'h0, u});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    reset_input_n = 1'b0;
    seed = 67;
    strap_pattern = 16'h0000;
    user_pattern = 8'h00;
    mac_txen = 8'h00;
    {init_started, selftest_busy, init_done, cksum_good} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    // corners first, then random patterns covering every identifier value
    for (int i = 0; i < 10; i++) begin
      exp_s = 16'($random(seed));
      exp_u = 8'($random(seed));
      if (i == 0) {exp_s, exp_u} = 24'h000000;
      if (i == 1) {exp_s, exp_u} = 24'hFFFFFF;
      exp_s[6:4] = i[2:0];
      // while sampling: only the first boot sees the all-zero reset word as a strap fault
      boot(exp_s, exp_u, (i == 0) ? 32'h0000000A : 32'h00000008);
      exp_s = fitted(exp_s);
      check_cfg(exp_s, exp_u);
      check_reg(OFS_STAT, 32'h1);
      $display("test boot %0d done", i);
    end
    // pins turn into status outputs once running
    check_reg(OFS_CTRL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      {init_started, selftest_busy, init_done, cksum_good} <= 4'($random(seed));
      mac_txen <= 8'($random(seed));
      repeat (3) @(posedge mclk);
      #1;
      check_field("status oe", 32'h1, {31'h0, strap_oe});
      check_field("status out", {28'h0, cksum_good, init_done, selftest_busy, init_started},
        {16'h0, strap_o});
      check_field("txen oe", 32'h1, {31'h0, txen_oe});
      check_field("txen out", {24'h0, mac_txen}, {24'h0, txen_o});
    end
    $display("test status done");
    // release the status pins, then move the board pattern under a running device
    reg_write(OFS_CTRL, 32'h0);
    repeat (3) @(posedge mclk);
    #1;
    check_field("status oe off", 32'h0, {31'h0, strap_oe});
    @(posedge mclk);
    strap_pattern <= ~strap_pattern;
    user_pattern <= ~user_pattern;
    repeat (12) @(posedge mclk);
    #1;
    check_cfg(exp_s, exp_u);
    $display("test hold done");
    // read-only and unmapped places
    reg_write(OFS_CFG, 32'hFFFFFFFF);
    reg_write(8'h10, 32'hFFFFFFFF);
    check_reg(8'h10, 32'h0);
    check_reg(OFS_CFG, {16'h0, exp_s});
    reg_write(OFS_CTRL, 32'h1);
    check_reg(OFS_CTRL, 32'h1);
    $display("test registers done");
    print_verdict();
  end
endmodule
